//--- design/pls_map.vh
// Register offsets, field positions, reset values and timing for the strap and indicator logic
`ifndef PLS_MAP_VH
`define PLS_MAP_VH

// ==========================================================
// Clock
`define PLS_CLK_MHZ 250

// ==========================================================
// Register offsets (byte addresses)
`define PLS_CTRL_OFS 4'h0
`define PLS_STAT_OFS 4'h4

// ==========================================================
// Control register fields
`define PLS_CTRL_ANEG_BIT 12
`define PLS_CTRL_SPEED_BIT 13
`define PLS_CTRL_MODE_LO 14
`define PLS_CTRL_MODE_HI 15
`define PLS_CTRL_MODE_RST 2'h0

// ==========================================================
// Status register fields
`define PLS_STAT_MODE0_BIT 0
`define PLS_STAT_MODE1_BIT 1
`define PLS_STAT_ANEG_BIT 2
`define PLS_STAT_SPEED_BIT 3
`define PLS_STAT_LINK_BIT 4
`define PLS_STAT_S100_BIT 5
`define PLS_STAT_BLINK_BIT 6
`define PLS_STAT_DONE_BIT 7

// ==========================================================
// Indicator mode encodings
`define PLS_MODE_LINK_ACT 2'h0
`define PLS_MODE_LINK_ONLY 2'h1

// ==========================================================
// Bus responses
`define PLS_RESP_OKAY 2'h0
`define PLS_RESP_SLVERR 2'h2

// ==========================================================
// Times: strap settle is a least time, blink half period a longest time
`define PLS_STRAP_SETTLE_NS 100
`define PLS_BLINK_HALF_US 50000
`define PLS_STRAP_SETTLE_CYC ((`PLS_STRAP_SETTLE_NS * `PLS_CLK_MHZ + 999) / 1000)
`define PLS_BLINK_HALF_CYC (`PLS_BLINK_HALF_US * `PLS_CLK_MHZ)

`endif

//--- design/pls_strap_capture.v
// Strap sampling sequencer for the dual-purpose pins
`timescale 1ns/10ps
`include "pls_map.vh"

module pls_strap_capture #(
  parameter SETTLE_CYC = `PLS_STRAP_SETTLE_CYC,
  parameter PINS = 4
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Pin levels while the pins float on their pulls
  input wire [PINS-1:0] pin_level,
  // Captured straps and end of configuration phase
  output reg [PINS-1:0] straps,
  output reg done,
  output reg done_pulse
);

  reg [15:0] cnt;

  // ==========================================================
  // Settle counter; straps are caught on the SETTLE_CYC-th clock after the release, never by the reset itself
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0000;
      straps <= {PINS{1'b0}};
      done <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (!done) begin
        if (cnt == SETTLE_CYC[15:0] - 16'h0001) begin
          straps <= pin_level; // Pull levels have settled by now
          done <= 1'b1;
          done_pulse <= 1'b1;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end

endmodule // pls_strap_capture

//--- design/pls_blink.v
// Activity blink generator shared by both indicators
`timescale 1ns/10ps

module pls_blink #(
  parameter HALF_CYC = 12500000,
  parameter CW = 24
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Activity pulse or level from the core
  input wire act,
  // Toggle phase, zero when idle
  output reg phase
);

  reg [CW-1:0] cnt;
  reg running;
  reg seen;

  // ==========================================================
  // Half-period timer; activity inside a half period keeps it toggling
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= {CW{1'b0}};
      running <= 1'b0;
      seen <= 1'b0;
      phase <= 1'b0;
    end else if (!running) begin
      cnt <= {CW{1'b0}};
      seen <= 1'b0;
      if (act) begin
        running <= 1'b1;
        phase <= 1'b1;
      end
    end else if (cnt == HALF_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
      cnt <= {CW{1'b0}};
      seen <= act; // New activity on the expiry edge is kept
      if (seen || act) begin
        phase <= ~phase;
      end else begin
        phase <= 1'b0; // Idle again, back to rest level
        running <= 1'b0;
      end
    end else begin
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
      if (act) begin
        seen <= 1'b1;
      end
    end
  end

endmodule // pls_blink

//--- design/pls_top.v
// Strap capture, MII status pins and programmable indicators behind an AXI4-Lite slave
//
// Summary of operation
// R1 - Collision pin drives MII collision after reset
// R2 - Carrier pin drives MII carrier sense after reset
// R3 - Collision pin strap becomes mode bit zero
// R4 - Carrier pin strap becomes mode bit one
// R5 - First indicator strap loads autoneg enable bit
// R6 - Mode 00: first indicator link, activity toggles
// R7 - Mode 01: first indicator shows link only
// R8 - Modes 10 and 11 reserved, undefined
// R9 - Second indicator strap loads speed select bit
// R10 - Mode 00: second indicator high 10, low 100
// R11 - Mode 01: second indicator shows activity
// R12 - Pins input during reset, outputs afterwards
// R13 - Activity indication idles high, toggles visibly
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "pls_map.vh"

module pls_top #(
  parameter BLINK_HALF_CYC = `PLS_BLINK_HALF_CYC,
  parameter BLINK_CW = 24,
  parameter SETTLE_CYC = `PLS_STRAP_SETTLE_CYC
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // Core status
  input wire MII_COL,
  input wire MII_CRS,
  input wire LINK_UP,
  input wire SPEED_100,
  input wire ACTIVITY,
  // Collision pin
  input wire COL_PIN_I,
  output reg COL_PIN_O,
  output reg COL_PIN_OE,
  // Carrier pin
  input wire CRS_PIN_I,
  output reg CRS_PIN_O,
  output reg CRS_PIN_OE,
  // First indicator pin
  input wire FIRST_INDICATOR_I,
  output reg FIRST_INDICATOR_OUT,
  output reg FIRST_INDICATOR_OE,
  // Second indicator pin
  input wire SECOND_INDICATOR_I,
  output reg SECOND_INDICATOR_OUT,
  output reg SECOND_INDICATOR_OE,
  // Configuration toward the core
  output reg MODE_STRAP_BIT_ZERO,
  output reg MODE_STRAP_BIT_ONE,
  output reg AUTONEG_ENABLE,
  output reg SPEED_SELECT,
  output reg CONFIG_DONE,
  // AXI4-Lite write address
  input wire [3:0] S_AXI_AWADDR,
  input wire [2:0] S_AXI_AWPROT,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  // AXI4-Lite write response
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read address
  input wire [3:0] S_AXI_ARADDR,
  input wire [2:0] S_AXI_ARPROT,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);

  // ==========================================================
  // Internal state
  wire [3:0] pin_level;
  wire [3:0] straps;
  wire strap_done;
  wire strap_done_pulse;
  wire blink_phase;
  reg [1:0] indicator_mode_field;
  reg autoneg_ctrl;
  reg speed_ctrl;
  reg aw_got;
  reg w_got;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg next_first;
  reg next_second;
  wire mode_strap_bit_zero;
  wire mode_strap_bit_one;
  wire autoneg_enable_strap;
  wire speed_strap;
  wire [31:0] ctrl_word;
  wire [31:0] stat_word;
  wire wr_ctrl;
  wire wr_hit;

  // ==========================================================
  // Strap sampling while the pins float
  // Bit order: collision, carrier, first indicator, second indicator
  assign pin_level = {SECOND_INDICATOR_I, FIRST_INDICATOR_I, CRS_PIN_I, COL_PIN_I};

  pls_strap_capture #(
    .SETTLE_CYC(SETTLE_CYC),
    .PINS(4)
  ) u_strap (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .pin_level(pin_level),
    .straps(straps),
    .done(strap_done),
    .done_pulse(strap_done_pulse)
  );

  // Named strap bits
  assign mode_strap_bit_zero = straps[0]; // see R3
  assign mode_strap_bit_one = straps[1]; // see R4
  assign autoneg_enable_strap = straps[2];
  assign speed_strap = straps[3];

  // ==========================================================
  // Activity blink, one timer serves both indicators
  pls_blink #(
    .HALF_CYC(BLINK_HALF_CYC),
    .CW(BLINK_CW)
  ) u_blink (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .act(ACTIVITY),
    .phase(blink_phase)
  );

  // ==========================================================
  // Indicator levels per mode; high is off
  always @* begin
    next_first = 1'b1;
    next_second = 1'b1;
    case (indicator_mode_field)
      `PLS_MODE_LINK_ACT: begin
        next_first = ~LINK_UP ^ blink_phase; // see R6
        next_second = ~SPEED_100; // see R10
      end
      `PLS_MODE_LINK_ONLY: begin
        next_first = ~LINK_UP; // see R7
        next_second = ~blink_phase; // see R11, see R13
      end
      default: begin
        // Reserved codes: keep both lamps off rather than guess
        next_first = 1'b1; // see R8
        next_second = 1'b1; // see R8
      end
    endcase
  end

  // ==========================================================
  // Pin drivers: released while straps are read, driven afterwards
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      COL_PIN_O <= 1'b0;
      COL_PIN_OE <= 1'b0;
      CRS_PIN_O <= 1'b0;
      CRS_PIN_OE <= 1'b0;
      FIRST_INDICATOR_OUT <= 1'b0;
      FIRST_INDICATOR_OE <= 1'b0;
      SECOND_INDICATOR_OUT <= 1'b0;
      SECOND_INDICATOR_OE <= 1'b0;
    end else begin
      COL_PIN_OE <= strap_done; // see R12
      CRS_PIN_OE <= strap_done; // see R12
      FIRST_INDICATOR_OE <= strap_done; // see R12
      SECOND_INDICATOR_OE <= strap_done; // see R12
      COL_PIN_O <= strap_done & MII_COL; // see R1
      CRS_PIN_O <= strap_done & MII_CRS; // see R2
      FIRST_INDICATOR_OUT <= strap_done & next_first;
      SECOND_INDICATOR_OUT <= strap_done & next_second;
    end
  end

  // ==========================================================
  // Configuration outputs toward the core
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MODE_STRAP_BIT_ZERO <= 1'b0;
      MODE_STRAP_BIT_ONE <= 1'b0;
      AUTONEG_ENABLE <= 1'b0;
      SPEED_SELECT <= 1'b0;
      CONFIG_DONE <= 1'b0;
    end else begin
      MODE_STRAP_BIT_ZERO <= mode_strap_bit_zero;
      MODE_STRAP_BIT_ONE <= mode_strap_bit_one;
      AUTONEG_ENABLE <= autoneg_ctrl;
      SPEED_SELECT <= speed_ctrl;
      CONFIG_DONE <= strap_done;
    end
  end

  // ==========================================================
  // Register layout
  // Control word at offset 0x0:
  //   [15:14] indicator mode, reset 00
  //   [13] speed select, loaded from second indicator strap
  //   [12] autoneg enable, loaded from first indicator strap
  //   Other bits read as zero, writes to them ignored
  //   Only the byte lane 1 strobe gates the write
  // Status word at offset 0x4, read only:
  //   [0] mode strap bit zero, collision pin
  //   [1] mode strap bit one, carrier pin
  //   [2] autoneg strap, first indicator pin
  //   [3] speed strap, second indicator pin
  //   [4] link state from the core
  //   [5] speed state from the core, high for 100
  //   [6] live blink phase
  //   [7] configuration done
  //   Writes answer OKAY and change nothing
  // Offsets 0x8 and 0xc answer SLVERR, reads give zero
  //
  // Bus timing
  // Write: response one clock after the later half is taken
  // Control bits change on that same edge
  // Address and data readies stay low until the response is taken
  // Read: data registered at the address handshake
  // Data stands until the read ready handshake
  // Protection inputs are not decoded
  //
  // Pin hazards
  // Straps are read before any pad driver turns on,
  // so a board pull never fights the device drive
  // A lamp pin pulled low on the board reads as a zero strap;
  // it still drives normally once configuration ends
  // Reserved modes park both lamps off, a visible hint
  // that software chose a code it should not use
  // One blink timer serves both lamps, but only one lamp
  // blinks in each mode, first in 00, second in 01; one counter traded for area
  // Straps are taken only after reset ends, so an async
  // reset edge cannot latch a half-settled level

  // ==========================================================
  // Register images
  assign ctrl_word = {16'h0000, indicator_mode_field, speed_ctrl, autoneg_ctrl, 12'h000};
  assign stat_word = {24'h00_0000, strap_done, blink_phase, SPEED_100, LINK_UP,
                      speed_strap, autoneg_enable_strap, mode_strap_bit_one, mode_strap_bit_zero};
  assign wr_hit = ({aw_addr[3:2], 2'b00} == `PLS_CTRL_OFS) || ({aw_addr[3:2], 2'b00} == `PLS_STAT_OFS);
  assign wr_ctrl = aw_got && w_got && !S_AXI_BVALID && ({aw_addr[3:2], 2'b00} == `PLS_CTRL_OFS);

  // ==========================================================
  // Control register; strap load wins over a write in the same cycle
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      indicator_mode_field <= `PLS_CTRL_MODE_RST;
      autoneg_ctrl <= 1'b0;
      speed_ctrl <= 1'b0;
    end else begin
      if (wr_ctrl && w_strb[1]) begin
        indicator_mode_field <= w_data[`PLS_CTRL_MODE_HI:`PLS_CTRL_MODE_LO];
        autoneg_ctrl <= w_data[`PLS_CTRL_ANEG_BIT];
        speed_ctrl <= w_data[`PLS_CTRL_SPEED_BIT];
      end
      if (strap_done_pulse) begin
        autoneg_ctrl <= autoneg_enable_strap; // see R5
        speed_ctrl <= speed_strap; // see R9
      end
    end
  end

  // ==========================================================
  // Write channels: address and data taken in either order
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PLS_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      // Both halves held: commit and answer
      if (aw_got && w_got && !S_AXI_BVALID) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? `PLS_RESP_OKAY : `PLS_RESP_SLVERR;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      // Readies come back only after the response is taken, one write at a time
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read channel; status is live, sampled at the address handshake
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `PLS_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        if ({S_AXI_ARADDR[3:2], 2'b00} == `PLS_CTRL_OFS) begin
          S_AXI_RDATA <= ctrl_word;
          S_AXI_RRESP <= `PLS_RESP_OKAY;
        end else if ({S_AXI_ARADDR[3:2], 2'b00} == `PLS_STAT_OFS) begin
          S_AXI_RDATA <= stat_word;
          S_AXI_RRESP <= `PLS_RESP_OKAY;
        end else begin
          S_AXI_RDATA <= 32'h0000_0000; // Unmapped reads zero with an error
          S_AXI_RRESP <= `PLS_RESP_SLVERR;
        end
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

endmodule // pls_top

//--- testbench/pls_top_props.sv
// Concurrent checks on the pins and bus handshakes of the strap and indicator block
`timescale 1ns/10ps

module pls_top_props (
  // Clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // Core status
  input wire MII_COL,
  input wire MII_CRS,
  // Pads
  input wire COL_PIN_I,
  input wire CRS_PIN_I,
  input wire COL_PIN_O,
  input wire CRS_PIN_O,
  input wire COL_PIN_OE,
  input wire CRS_PIN_OE,
  input wire FIRST_INDICATOR_OE,
  input wire SECOND_INDICATOR_OE,
  // Configuration
  input wire MODE_STRAP_BIT_ZERO,
  input wire MODE_STRAP_BIT_ONE,
  input wire CONFIG_DONE,
  // Bus handshakes
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  // ==========================================================
  // Clocking
  // All checks rest while reset is low
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);

  // ==========================================================
  // Pin checks
  // Status pins copy the core one clock late once configured
  a_col_follow: assert property (CONFIG_DONE && $past(CONFIG_DONE) |-> COL_PIN_O == $past(MII_COL))
    else $error("collision pin lost the core value");
  a_crs_follow: assert property (CONFIG_DONE && $past(CONFIG_DONE) |-> CRS_PIN_O == $past(MII_CRS))
    else $error("carrier pin lost the core value");
  // Pads float on their pulls until configuration ends
  a_oe_phase: assert property (COL_PIN_OE == CONFIG_DONE && CRS_PIN_OE == CONFIG_DONE
    && FIRST_INDICATOR_OE == CONFIG_DONE && SECOND_INDICATOR_OE == CONFIG_DONE)
    else $error("pad drive out of step with configuration");
  // Strap bits hold the floating pad levels
  a_strap_load: assert property ($rose(CONFIG_DONE) |=> MODE_STRAP_BIT_ZERO == $past(COL_PIN_I, 2)
    && MODE_STRAP_BIT_ONE == $past(CRS_PIN_I, 2))
    else $error("mode straps differ from pad levels");
  a_strap_keep: assert property (CONFIG_DONE && $past(CONFIG_DONE) |-> $stable(MODE_STRAP_BIT_ZERO)
    && $stable(MODE_STRAP_BIT_ONE))
    else $error("mode straps changed after configuration");

  // ==========================================================
  // Bus checks
  // One answer per request
  a_r_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  a_b_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_ar_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
endmodule // pls_top_props

bind pls_top pls_top_props u_props (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .MII_COL(MII_COL), .MII_CRS(MII_CRS),
  .COL_PIN_I(COL_PIN_I), .CRS_PIN_I(CRS_PIN_I), .COL_PIN_O(COL_PIN_O), .CRS_PIN_O(CRS_PIN_O),
  .COL_PIN_OE(COL_PIN_OE), .CRS_PIN_OE(CRS_PIN_OE),
  .FIRST_INDICATOR_OE(FIRST_INDICATOR_OE), .SECOND_INDICATOR_OE(SECOND_INDICATOR_OE),
  .MODE_STRAP_BIT_ZERO(MODE_STRAP_BIT_ZERO), .MODE_STRAP_BIT_ONE(MODE_STRAP_BIT_ONE),
  .CONFIG_DONE(CONFIG_DONE), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);

//--- testbench/pls_pads.sv
// Board model of the strap resistors on the four dual-purpose pads
`timescale 1ns/10ps

module pls_pads (
  // Pull levels fitted on the board
  input wire [3:0] pull,
  // Device drive, order collision, carrier, first, second
  input wire [3:0] pad_o,
  input wire [3:0] pad_oe,
  // Resolved pad levels
  output wire [3:0] pad_i
);
  // ==========================================================
  // Pad resolution
  // Pull wins only where the device lets go, so a stale level never shows
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & pull);
endmodule // pls_pads

//--- testbench/test_pls_top.sv
// Self-checking bench for the strap, status pin and indicator logic
`timescale 1ns/10ps
`include "pls_map.vh"

module test_pls_top;
  reg clk = 1'b0;
  reg arst_n = 1'b1; // Falls at time zero so the reset edge is seen
  reg col = 1'b0, crs = 1'b0, link = 1'b0, s100 = 1'b0, act = 1'b0, lvl;
  reg [3:0] pull = 4'h0, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  reg [31:0] wdata = 32'h0000_0000, lfsr_q = 32'h0000_23af;
  reg awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, done;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] pad_i, pad_o, pad_oe, st;
  reg [33:0] rq[$];
  reg [1:0] bq[$];
  integer fail_count = 0, total_checks = 0, cyc = 0, i, k, n;

  // ==========================================================
  // Clock, pads and design
  always #2 clk = ~clk;
  pls_pads U_PADS (.pull(pull), .pad_o(pad_o), .pad_oe(pad_oe), .pad_i(pad_i));
  pls_top #(.BLINK_HALF_CYC(8), .BLINK_CW(24), .SETTLE_CYC(4)) DUT (
    .SYS_CLK(clk), .ARST_N(arst_n), .MII_COL(col), .MII_CRS(crs), .LINK_UP(link), .SPEED_100(s100),
    .ACTIVITY(act), .COL_PIN_I(pad_i[0]), .COL_PIN_O(pad_o[0]), .COL_PIN_OE(pad_oe[0]),
    .CRS_PIN_I(pad_i[1]), .CRS_PIN_O(pad_o[1]), .CRS_PIN_OE(pad_oe[1]),
    .FIRST_INDICATOR_I(pad_i[2]), .FIRST_INDICATOR_OUT(pad_o[2]), .FIRST_INDICATOR_OE(pad_oe[2]),
    .SECOND_INDICATOR_I(pad_i[3]), .SECOND_INDICATOR_OUT(pad_o[3]), .SECOND_INDICATOR_OE(pad_oe[3]),
    .MODE_STRAP_BIT_ZERO(st[0]), .MODE_STRAP_BIT_ONE(st[1]), .AUTONEG_ENABLE(st[2]),
    .SPEED_SELECT(st[3]), .CONFIG_DONE(done),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // ==========================================================
  // Helpers
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input [33:0] e, input [33:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask

  task end_sim;
    begin
      if (fail_count == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Address and data may be taken on different edges
  task wr(input [3:0] a, input [31:0] d, input [1:0] e);
    reg aw_ok, w_ok;
    begin
      bq.push_back(e);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
        @(posedge clk);
        if (awready === 1'b1 && !aw_ok) begin
          aw_ok = 1'b1;
          awvalid <= 1'b0;
        end
        if (wready === 1'b1 && !w_ok) begin
          w_ok = 1'b1;
          wvalid <= 1'b0;
        end
      end
      @(posedge clk);
      while (bvalid !== 1'b1) @(posedge clk);
      bready <= 1'b0;
      @(posedge clk); // One idle edge so the next call never re-raises in this step
    end
  endtask

  task rd(input [3:0] a, input [33:0] e);
    begin
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge clk);
      while (arready !== 1'b1) @(posedge clk);
      arvalid <= 1'b0;
      @(posedge clk);
      while (rvalid !== 1'b1) @(posedge clk);
      rready <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Reset with given pulls, then check what was latched
  task boot(input [3:0] p);
    begin
      pull <= p;
      arst_n <= 1'b0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      while (done !== 1'b1) @(posedge clk);
      @(posedge clk); // Control bits reach their outputs one edge after done
      chk({30'h0, p}, {30'h0, st});
      rd(`PLS_CTRL_OFS, {18'h0_0000, 2'h0, p[3], p[2], 12'h000});
      rd(`PLS_STAT_OFS, {26'h000_0000, 1'b1, 1'b0, s100, link, p});
    end
  endtask

  // ==========================================================
  // Random core status, timeout and answer monitor
  always @(posedge clk) begin
    lfsr_q <= lfsr(lfsr_q);
    col <= lfsr_q[0];
    crs <= lfsr_q[5];
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end

  // Oldest note is matched against each answer
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk(rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) chk({32'h0, bq.pop_front()}, {32'h0, bresp});
  end

  // ==========================================================
  // Main sequence
  initial begin
    boot(4'h5);
    // Every mode against every link and speed combination
    for (k = 0; k < 4; k = k + 1) begin
      wr(`PLS_CTRL_OFS, {16'h0000, k[1:0], 14'h0000}, `PLS_RESP_OKAY);
      rd(`PLS_CTRL_OFS, {18'h0_0000, k[1:0], 14'h0000});
      for (i = 0; i < 4; i = i + 1) begin
        link <= i[0];
        s100 <= i[1];
        repeat (3) @(posedge clk);
        chk({30'h0, k > 1 ? 2'h3 : {~i[0], k[0] | ~i[1]}, 2'h3}, {30'h0, pad_o[2], pad_o[3], pad_oe[2], pad_oe[3]});
      end
    end
    // Activity blinks, then idles: first pin in mode 00, second in 01
    link <= 1'b1;
    for (k = 0; k < 2; k = k + 1) begin
      wr(`PLS_CTRL_OFS, {16'h0000, k[1:0], 14'h0000}, `PLS_RESP_OKAY);
      act <= 1'b1;
      n = 0;
      lvl = pad_o[2 + k];
      repeat (40) begin
        @(posedge clk);
        if (pad_o[2 + k] !== lvl) n = n + 1;
        lvl = pad_o[2 + k];
      end
      chk({33'h0, 1'b1}, {33'h0, n > 2 && n < 7});
      act <= 1'b0;
      repeat (40) @(posedge clk);
      chk({33'h0, k[0]}, {33'h0, pad_o[2 + k]});
    end
    // Read-only and unmapped places leave the control word alone
    wr(`PLS_STAT_OFS, 32'hffff_ffff, `PLS_RESP_OKAY);
    wr(4'h8, 32'hffff_ffff, `PLS_RESP_SLVERR);
    // Lane 1 strobe low: the control word must keep mode 01
    wstrb <= 4'hd;
    wr(`PLS_CTRL_OFS, 32'h0000_0000, `PLS_RESP_OKAY);
    wstrb <= 4'hf;
    rd(4'hc, {`PLS_RESP_SLVERR, 32'h0000_0000});
    rd(`PLS_CTRL_OFS, {18'h0_0000, 2'h1, 14'h0000});
    rd(`PLS_STAT_OFS, {26'h000_0000, 1'b1, 1'b0, s100, link, 4'h5});
    chk(34'h0, {32'h0, st[3:2]});
    // Second reset mid-run with the opposite pulls
    boot(4'ha);
    end_sim;
  end
endmodule // test_pls_top
